// [core/psd_pkg.sv]
// Shared constants for the pipelined SRAM data port.
// Function
// RULE_01 - Qualifier high freezes all state and never deselects.
// RULE_02 - Data lanes are captured into a data register on each qualified clock rise.
// RULE_03 - Read data appears one qualified rise after the read address.
// RULE_04 - Lanes are driven only while the output drive enable is low.
// RULE_05 - Lanes float in write data, first cycle after deselect, deselected.
// RULE_06 - Parity lanes behave exactly like the data lanes.
// RULE_07 - A parity lane is written only when its byte select is asserted.
// RULE_08 - Strap high gives interleaved burst order, strap low gives linear.
// RULE_09 - An unconnected strap reads as high, so interleaved order; the code has no pull-up, so a floating strap gives linear order.
// RULE_10 - The system keeps the strap constant while accesses run.
// RULE_11 - A read starts with all selects active, write select high, load low.
// RULE_12 - Write data is latched at the second rise after its address.
// RULE_13 - Burst counter wraps the two low bits and advances on every advance.
// RULE_14 - After a deselecting rise, outputs float following the next rise.
// RULE_15 - Linear adds one modulo four; interleaved xors start with step.
package psd_pkg;

    // ------------------------------------------------------------------
    // Geometry of the array and the lanes.
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 18;
    localparam int LANES   = 4;
    localparam int BYTE_W  = 8;
    localparam int LANE_W  = BYTE_W + 1;
    localparam int DATA_W  = LANES * BYTE_W;
    localparam int WORD_W  = LANES * LANE_W;
    localparam int BURST_W = 2;
    localparam int DEPTH   = 1 << ADDR_W;

    // ------------------------------------------------------------------
    // Reset values and advance step of the control pipeline.
    // ------------------------------------------------------------------
    localparam logic [BURST_W-1:0] STEP_RST = 2'h0;
    localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
    localparam logic [ADDR_W-1:0]  ADDR_RST = 18'h00000;
    localparam logic [DATA_W-1:0]  DATA_RST = 32'h00000000;
    localparam logic [LANES-1:0]   LANE_RST = 4'h0;

    // Burst order selected by the strap level.
    typedef enum logic {
        PSD_ORDER_LINEAR     = 1'b0,
        PSD_ORDER_INTERLEAVE = 1'b1
    } psd_order_e;

endpackage

// [core/psd_store.sv]
// Word array with per-lane write enables and an indexed read port.
`timescale 1ns/1ns
module psd_store (
    input  wire logic                                       core_clk,
    input  wire logic                                       wr_en,
    input  wire logic [psd_pkg::LANES-1:0]                  wr_lanes,
    input  wire logic [psd_pkg::ADDR_W-1:0]                 wr_addr,
    input  wire logic [psd_pkg::WORD_W-1:0]                 wr_word,
    input  wire logic [psd_pkg::ADDR_W-1:0]                 rd_addr,
    output logic      [psd_pkg::WORD_W-1:0]                 rd_word
);

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    // The array holds data only; it has no reset, like the real cells.
    logic [psd_pkg::WORD_W-1:0] mem_q [psd_pkg::DEPTH];

    // Each lane of nine bits carries a byte and its parity bit together.
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < psd_pkg::LANES; i++) begin
            if (wr_en && wr_lanes[i]) begin
                mem_q[wr_addr][i*psd_pkg::LANE_W +: psd_pkg::LANE_W] <=
                    wr_word[i*psd_pkg::LANE_W +: psd_pkg::LANE_W];
            end
        end
    end

    // Read is combinational; the caller registers it into the output stage.
    assign rd_word = mem_q[rd_addr];

endmodule

// [core/psd_port.sv]
// Top of the pipelined SRAM data port: control pipeline, burst, lanes.
`timescale 1ns/1ns
module psd_port (
    input  wire logic                                       core_clk,
    input  wire logic                                       arst_n,
    input  wire logic                                       clock_qualifier_n,
    input  wire logic                                       chip_select_1_n,
    input  wire logic                                       chip_select_2,
    input  wire logic                                       chip_select_3_n,
    input  wire logic                                       write_enable_n,
    input  wire logic                                       advance_or_load,
    input  wire logic [psd_pkg::ADDR_W-1:0]                 addr,
    input  wire logic [psd_pkg::LANES-1:0]                  byte_write_select_n,
    input  wire logic                                       output_drive_n,
    input  wire logic                                       burst_order,
    input  wire logic [psd_pkg::DATA_W-1:0]                 dq_in,
    output logic      [psd_pkg::DATA_W-1:0]                 dq_out,
    output logic                                            dq_oe_n,
    input  wire logic [psd_pkg::LANES-1:0]                  parity_lanes_in,
    output logic      [psd_pkg::LANES-1:0]                  parity_lanes_out,
    output logic                                            parity_lanes_oe_n
);

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------
    // Interleave byte and parity into nine-bit lanes.
    function automatic logic [psd_pkg::WORD_W-1:0] pack_word(
        input logic [psd_pkg::DATA_W-1:0] d,
        input logic [psd_pkg::LANES-1:0]  p);
        logic [psd_pkg::WORD_W-1:0] w;
        w = '0;
        for (int i = 0; i < psd_pkg::LANES; i++) begin
            w[i*psd_pkg::LANE_W +: psd_pkg::LANE_W] =
                {p[i], d[i*psd_pkg::BYTE_W +: psd_pkg::BYTE_W]};
        end
        return w;
    endfunction

    // Two low address bits for a given burst step.
    function automatic logic [psd_pkg::BURST_W-1:0] burst_low(
        input logic [psd_pkg::BURST_W-1:0] start,
        input logic [psd_pkg::BURST_W-1:0] step,
        input logic                        order);
        logic [psd_pkg::BURST_W-1:0] r;
        r = start + step;                                 // [RULE_15]
        if (order == psd_pkg::PSD_ORDER_INTERLEAVE) begin
            r = start ^ step;                             // [RULE_08]
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Decodes of the sampled control pins.
    // ------------------------------------------------------------------
    logic qual;
    logic sel;
    logic load;
    assign qual = ~clock_qualifier_n;
    assign sel  = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
    assign load = ~advance_or_load;

    // ------------------------------------------------------------------
    // Burst counter and first pipeline stage (address phase).
    // ------------------------------------------------------------------
    logic [psd_pkg::ADDR_W-1:0]  base_q,  base_d;
    logic [psd_pkg::BURST_W-1:0] step_q,  step_d;
    logic                        bwr_q,   bwr_d;
    logic                        bact_q,  bact_d;
    logic                        s1_vld_q, s1_vld_d;
    logic                        s1_wr_q,  s1_wr_d;
    logic [psd_pkg::ADDR_W-1:0]  s1_addr_q, s1_addr_d;
    logic [psd_pkg::LANES-1:0]   s1_bw_q,  s1_bw_d;

    // A high qualifier simply holds every register, which extends the
    // previous cycle without touching the selection state.
    always_comb begin
        base_d    = base_q;
        step_d    = step_q;
        bwr_d     = bwr_q;
        bact_d    = bact_q;
        s1_vld_d  = s1_vld_q;
        s1_wr_d   = s1_wr_q;
        s1_addr_d = s1_addr_q;
        s1_bw_d   = s1_bw_q;
        if (qual) begin                                   // [RULE_01]
            s1_bw_d = ~byte_write_select_n;
            if (load) begin
                base_d    = addr;
                step_d    = psd_pkg::STEP_RST;
                bwr_d     = ~write_enable_n;
                bact_d    = sel;
                s1_vld_d  = sel;
                s1_wr_d   = ~write_enable_n;
                s1_addr_d = addr;
            end else begin
                // Advance ignores selects and write select entirely.
                step_d    = step_q + psd_pkg::STEP_ONE;   // [RULE_13]
                s1_vld_d  = bact_q;
                s1_wr_d   = bwr_q;
                // A floating strap is not pulled high here, so it fails the interleave test and takes linear order.
                s1_addr_d = {base_q[psd_pkg::ADDR_W-1:psd_pkg::BURST_W],
                             burst_low(base_q[psd_pkg::BURST_W-1:0],
                                       step_d, burst_order)}; // [RULE_09]
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            base_q    <= psd_pkg::ADDR_RST;
            step_q    <= psd_pkg::STEP_RST;
            bwr_q     <= 1'b0;
            bact_q    <= 1'b0;
            s1_vld_q  <= 1'b0;
            s1_wr_q   <= 1'b0;
            s1_addr_q <= psd_pkg::ADDR_RST;
            s1_bw_q   <= psd_pkg::LANE_RST;
        end else begin
            base_q    <= base_d;
            step_q    <= step_d;
            bwr_q     <= bwr_d;
            bact_q    <= bact_d;
            s1_vld_q  <= s1_vld_d;
            s1_wr_q   <= s1_wr_d;
            s1_addr_q <= s1_addr_d;
            s1_bw_q   <= s1_bw_d;
        end
    end

    // ------------------------------------------------------------------
    // Second stage (write data phase) and output register.
    // ------------------------------------------------------------------
    logic                        s2_wr_q,   s2_wr_d;
    logic [psd_pkg::ADDR_W-1:0]  s2_addr_q, s2_addr_d;
    logic [psd_pkg::LANES-1:0]   s2_bw_q,   s2_bw_d;
    logic                        drive_q,   drive_d;
    logic [psd_pkg::DATA_W-1:0]  dout_q,    dout_d;
    logic [psd_pkg::LANES-1:0]   pout_q,    pout_d;
    logic [psd_pkg::DATA_W-1:0]  din_q,     din_d;
    logic [psd_pkg::LANES-1:0]   pin_q,     pin_d;
    logic [psd_pkg::WORD_W-1:0]  rd_word;
    logic [psd_pkg::WORD_W-1:0]  pin_word;
    logic [psd_pkg::WORD_W-1:0]  fwd_word;
    logic                        mem_we;

    assign pin_word = pack_word(dq_in, parity_lanes_in);
    assign mem_we   = qual & s2_wr_q;                     // [RULE_12]

    // A read that follows a write to the same word sees the data being
    // written in this very cycle, so the selected lanes are forwarded.
    always_comb begin
        fwd_word = rd_word;
        if (mem_we && (s2_addr_q == s1_addr_q)) begin
            for (int i = 0; i < psd_pkg::LANES; i++) begin
                if (s2_bw_q[i]) begin
                    fwd_word[i*psd_pkg::LANE_W +: psd_pkg::LANE_W] =
                        pin_word[i*psd_pkg::LANE_W +: psd_pkg::LANE_W];
                end
            end
        end
    end

    // Drive starts only one rise after a selected read; a write data
    // phase or a deselect leaves it low on its own.
    always_comb begin
        s2_wr_d   = s2_wr_q;
        s2_addr_d = s2_addr_q;
        s2_bw_d   = s2_bw_q;
        drive_d   = drive_q;
        dout_d    = dout_q;
        pout_d    = pout_q;
        din_d     = din_q;
        pin_d     = pin_q;
        if (qual) begin
            s2_wr_d   = s1_vld_q & s1_wr_q;
            s2_addr_d = s1_addr_q;
            s2_bw_d   = s1_bw_q;
            drive_d   = s1_vld_q & ~s1_wr_q;              // [RULE_05] [RULE_14]
            din_d     = dq_in;                            // [RULE_02]
            pin_d     = parity_lanes_in;
            for (int i = 0; i < psd_pkg::LANES; i++) begin
                dout_d[i*psd_pkg::BYTE_W +: psd_pkg::BYTE_W] =
                    fwd_word[i*psd_pkg::LANE_W +: psd_pkg::BYTE_W]; // [RULE_03]
                pout_d[i] = fwd_word[i*psd_pkg::LANE_W + psd_pkg::BYTE_W];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s2_wr_q   <= 1'b0;
            s2_addr_q <= psd_pkg::ADDR_RST;
            s2_bw_q   <= psd_pkg::LANE_RST;
            drive_q   <= 1'b0;
            dout_q    <= psd_pkg::DATA_RST;
            pout_q    <= psd_pkg::LANE_RST;
            din_q     <= psd_pkg::DATA_RST;
            pin_q     <= psd_pkg::LANE_RST;
        end else begin
            s2_wr_q   <= s2_wr_d;
            s2_addr_q <= s2_addr_d;
            s2_bw_q   <= s2_bw_d;
            drive_q   <= drive_d;
            dout_q    <= dout_d;
            pout_q    <= pout_d;
            din_q     <= din_d;
            pin_q     <= pin_d;
        end
    end

    // ------------------------------------------------------------------
    // Storage and lanes.
    // ------------------------------------------------------------------
    // Lane enables carry byte and parity together, so an unselected
    // parity bit is never disturbed.
    psd_store u_store (
        .core_clk (core_clk),
        .wr_en    (mem_we),
        .wr_lanes (s2_bw_q),                              // [RULE_07]
        .wr_addr  (s2_addr_q),
        .wr_word  (pin_word),
        .rd_addr  (s1_addr_q),
        .rd_word  (rd_word)
    );

    // The drive enable must follow its pin without a clock, so the two
    // enables are the outputs that are not plain flops: a flop gated by that pin.
    assign dq_out            = dout_q;
    assign parity_lanes_out  = pout_q;
    assign dq_oe_n           = ~drive_q | output_drive_n; // [RULE_04]
    assign parity_lanes_oe_n = ~drive_q | output_drive_n; // [RULE_06]

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence read_issue_s;
        qual && load && sel && write_enable_n;
    endsequence

    sequence deselect_s;
        qual && load && !sel;
    endsequence

    sequence linear_pair_s;
        (qual && advance_or_load && !burst_order) ##1
        (qual && advance_or_load && !burst_order);
    endsequence

    hold_on_stall_a: assert property ( // [RULE_01]
        clock_qualifier_n |=> $stable(dout_q) && $stable(drive_q)
                              && $stable(s1_addr_q) && $stable(step_q))
        else $error("state changed while the clock was not qualified");

    data_capture_a: assert property ( // [RULE_02]
        qual |=> din_q == $past(dq_in) && pin_q == $past(parity_lanes_in))
        else $error("lane inputs not captured on a qualified rise");

    // A read straight after a deselect must not drive at its own rise.
    desel_first_a: assert property ( // [RULE_05]
        deselect_s ##1 read_issue_s |=> !drive_q)
        else $error("lanes driven in the first cycle after a deselect");

    read_data_a: assert property ( // [RULE_03]
        read_issue_s ##1 qual |=> drive_q)
        else $error("read did not drive one rise after its address");

    drive_gate_a: assert property ( // [RULE_04]
        output_drive_n |-> dq_oe_n && parity_lanes_oe_n)
        else $error("lanes driven while the drive enable is high");

    write_float_a: assert property ( // [RULE_05]
        s2_wr_q |-> dq_oe_n)
        else $error("lanes driven during a write data phase");

    parity_same_a: assert property ( // [RULE_06]
        dq_oe_n == parity_lanes_oe_n)
        else $error("parity lanes differ in direction from data lanes");

    parity_lane_a: assert property ( // [RULE_07]
        mem_we |-> u_store.wr_lanes == s2_bw_q && s2_wr_q)
        else $error("lane write enables differ from the byte selects");

    write_rise_a: assert property ( // [RULE_12]
        (qual && load && sel && !write_enable_n) ##1 qual ##1 qual
            |-> mem_we && s2_addr_q == $past(addr, 2))
        else $error("write data not latched at the second rise");

    step_adv_a: assert property ( // [RULE_13]
        qual && advance_or_load |=> step_q == $past(step_q) + 2'h1)
        else $error("burst counter failed to advance");

    linear_order_a: assert property ( // [RULE_08]
        linear_pair_s |=> s1_addr_q[1:0] == $past(s1_addr_q[1:0]) + 2'h1)
        else $error("linear burst did not add one");

    deselect_float_a: assert property ( // [RULE_14]
        deselect_s ##1 qual |=> !drive_q)
        else $error("outputs still driven after a deselect");

endmodule

// [dv/psd_ctrl_model.sv]
// Behavioural memory controller that drives the data port's pins.
`timescale 1ns/1ns
module psd_ctrl_model (
    input  wire logic        core_clk,
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe_n,
    input  wire logic [3:0]  parity_lanes_out,
    input  wire logic        parity_lanes_oe_n,
    output logic             clock_qualifier_n,
    output logic             chip_select_1_n,
    output logic             chip_select_2,
    output logic             chip_select_3_n,
    output logic             write_enable_n,
    output logic             advance_or_load,
    output logic [17:0]      addr,
    output logic [3:0]       byte_write_select_n,
    output logic [31:0]      dq_in,
    output logic [3:0]       parity_lanes_in
);
    logic        drv_q;
    logic [35:0] word_q;
    logic [35:0] flt_q;

    // Idle state at time zero: qualified clock, device deselected.
    initial begin
        clock_qualifier_n   = 1'b0;
        chip_select_1_n     = 1'b1;
        chip_select_2       = 1'b0;
        chip_select_3_n     = 1'b1;
        write_enable_n      = 1'b1;
        advance_or_load     = 1'b0;
        addr                = 18'h00000;
        byte_write_select_n = 4'hf;
        drv_q               = 1'b0;
        word_q              = 36'h000000000;
        flt_q               = 36'h5a5a5a5a5;
    end

    // A released lane toggles every cycle so no stale value reads back.
    always @(posedge core_clk) flt_q <= ~flt_q;

    // The wire level: device, controller, or a changing float pattern.
    assign dq_in = !dq_oe_n ? dq_out : (drv_q ? word_q[31:0] : flt_q[31:0]);
    assign parity_lanes_in = !parity_lanes_oe_n ? parity_lanes_out :
                             (drv_q ? word_q[35:32] : flt_q[35:32]);

    // One bus cycle: pins change at the falling edge and stand for the rise.
    task automatic cyc(input logic sel, input logic we_n, input logic adv,
                       input logic [17:0] a, input logic [3:0] bw_n,
                       input logic drv, input logic [35:0] w,
                       input logic cq_n);
        @(negedge core_clk);
        clock_qualifier_n   = cq_n;
        chip_select_1_n     = ~sel;
        chip_select_2       = sel;
        chip_select_3_n     = ~sel;
        write_enable_n      = we_n;
        advance_or_load     = adv;
        addr                = a;
        byte_write_select_n = bw_n;
        drv_q               = drv;
        word_q              = w;
        @(posedge core_clk);
        #2;
    endtask
endmodule

// [dv/psd_port_tb.sv]
// Self-checking testbench for the pipelined SRAM data port.
`timescale 1ns/1ns
module psd_port_tb;
    logic        core_clk;
    logic        arst_n;
    logic        output_drive_n;
    logic        burst_order;
    logic        cq_n;
    logic        cs1_n;
    logic        cs2;
    logic        cs3_n;
    logic        we_n;
    logic        adv;
    logic [17:0] addr;
    logic [3:0]  bw_n;
    logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic        dq_oe_n;
    logic [3:0]  par_in;
    logic [3:0]  par_out;
    logic        par_oe_n;
    int          n_mismatch;
    int          tests_run;

    psd_port u_dut (.core_clk(core_clk), .arst_n(arst_n),
        .clock_qualifier_n(cq_n), .chip_select_1_n(cs1_n),
        .chip_select_2(cs2), .chip_select_3_n(cs3_n),
        .write_enable_n(we_n), .advance_or_load(adv), .addr(addr),
        .byte_write_select_n(bw_n), .output_drive_n(output_drive_n),
        .burst_order(burst_order), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .parity_lanes_in(par_in),
        .parity_lanes_out(par_out), .parity_lanes_oe_n(par_oe_n));

    psd_ctrl_model u_ctrl (
        .core_clk(core_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .parity_lanes_out(par_out), .parity_lanes_oe_n(par_oe_n),
        .clock_qualifier_n(cq_n), .chip_select_1_n(cs1_n),
        .chip_select_2(cs2), .chip_select_3_n(cs3_n),
        .write_enable_n(we_n), .advance_or_load(adv), .addr(addr),
        .byte_write_select_n(bw_n), .dq_in(dq_in), .parity_lanes_in(par_in));

    // Fifty megahertz clock.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Distinct word per address, so a wrong beat shows at once.
    function automatic logic [35:0] pat(input logic [17:0] a);
        return {a[3:0] ^ 4'h5, 14'h2b3c, a};
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [35:0] exp,
                       input logic [35:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle(input logic drv, input logic [35:0] w);
        u_ctrl.cyc(1'b0, 1'b1, 1'b0, 18'h00000, 4'hf, drv, w, 1'b0);
    endtask

    // Write: lanes float in the data phase, data goes on the second rise.
    task automatic wr(input logic [17:0] a, input logic [3:0] bw,
                      input logic [35:0] w);
        u_ctrl.cyc(1'b1, 1'b0, 1'b0, a, bw, 1'b0, 36'h000000000, 1'b0);
        idle(1'b0, 36'h000000000);
        chk("oe write", 36'h3, {34'h0, dq_oe_n, par_oe_n});
        idle(1'b1, w);
    endtask

    task automatic rd(input logic [17:0] a, input logic [35:0] exp);
        u_ctrl.cyc(1'b1, 1'b1, 1'b0, a, 4'hf, 1'b0, 36'h000000000, 1'b0);
        chk("oe first", 36'h3, {34'h0, dq_oe_n, par_oe_n});
        idle(1'b0, 36'h000000000);
        chk("oe read", 36'h0, {34'h0, dq_oe_n, par_oe_n});
        chk("read", exp, {par_out, dq_out});
    endtask

    task automatic t_write_read();
        wr(18'h00123, 4'h0, pat(18'h00123));
        rd(18'h00123, pat(18'h00123));
        $display("test write_read done");
    endtask

    // Lanes 0 and 2 are selected; lanes 1 and 3 keep the old ones.
    task automatic t_byte_lanes();
        wr(18'h00200, 4'h0, 36'hfffffffff);
        wr(18'h00200, 4'ha, 36'h000000000);
        rd(18'h00200, {4'ha, 32'hff00ff00});
        $display("test byte_lanes done");
    endtask

    // A frozen rise, drive permission, then the pipelined float.
    task automatic t_drive_hold();
        u_ctrl.cyc(1'b1, 1'b1, 1'b0, 18'h00123, 4'hf, 1'b0, 36'h0, 1'b0);
        idle(1'b0, 36'h000000000);
        // The frozen rise follows the drive rise at once, so nothing moves.
        u_ctrl.cyc(1'b0, 1'b0, 1'b0, 18'h3ffff, 4'h0, 1'b0, 36'h0, 1'b1);
        chk("held", pat(18'h00123), {par_out, dq_out});
        @(negedge core_clk);
        output_drive_n = 1'b1;
        #2;
        chk("oe gated", 36'h3, {34'h0, dq_oe_n, par_oe_n});
        @(negedge core_clk);
        output_drive_n = 1'b0;
        #2;
        chk("oe held", 36'h0, {34'h0, dq_oe_n, par_oe_n});
        idle(1'b0, 36'h000000000);
        chk("oe desel", 36'h3, {34'h0, dq_oe_n, par_oe_n});
        $display("test drive_hold done");
    endtask

    // Burst from start 1 in both orders, wrapping the two low bits.
    task automatic t_burst();
        logic [1:0]  s;
        logic [17:0] b;
        logic [35:0] e;
        logic [35:0] g;
        for (int o = 0; o < 2; o++) begin
            burst_order = o[0];
            b = 18'h00040;
            for (int i = 0; i < 4; i++) begin
                wr(b + 18'(i), 4'h0, pat(b + 18'(i)));
            end
            u_ctrl.cyc(1'b1, 1'b1, 1'b0, b + 18'h1, 4'hf, 1'b0, 36'h0, 1'b0);
            for (int k = 0; k < 4; k++) begin
                u_ctrl.cyc(1'b0, 1'b0, k < 3, 18'h00000, 4'hf, 1'b0,
                           36'h0, 1'b0);
                s = o[0] ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
                e = pat(b + 18'(s));
                g = {par_out, dq_out};
                chk("beat", e, g);
            end
            idle(1'b0, 36'h000000000);
        end
        burst_order = 1'b1;
        $display("test burst done");
    endtask

    // Main sequence after a sixteen-cycle reset.
    initial begin
        n_mismatch     = 0;
        tests_run      = 0;
        arst_n         = 1'b0;
        output_drive_n = 1'b0;
        burst_order    = 1'b1;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        chk("oe reset", 36'h3, {34'h0, dq_oe_n, par_oe_n});
        t_write_read();
        t_byte_lanes();
        t_drive_hold();
        t_burst();
        test_done();
    end

    // A hang is cut short after a fixed budget of cycles.
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        test_done();
    end
endmodule
